// *** rri_consts.svh ***
`ifndef RRI_CONSTS_SVH
`define RRI_CONSTS_SVH

// Datapath widths
`define RRI_DATA_W        8
`define RRI_PC_W          15
`define RRI_FADDR_W       7

// Hardware call stack
`define RRI_STACK_DEPTH   16
`define RRI_SP_W          4

// Field positions
`define RRI_GIE_BIT       7
`define RRI_MSB_BIT       7

// Timing counts in instruction cycles; instruction size in words
`define RRI_RET_CYCLES    2
`define RRI_ROT_CYCLES    1
`define RRI_WORDS_PER_OP  1

// Reset values
`define RRI_PC_RST        15'h0000
`define RRI_ACC_RST       8'h00
`define RRI_CARRY_RST     1'b0
`define RRI_INTERRUPT_CONTROL_REG_RST    8'h00
`define RRI_FADDR_RST     7'h00
`define RRI_SP_RST        4'h0

`endif

// *** rri_pkg.sv ***
package rri_pkg;
    // Instruction selector presented by the fetch stage
    typedef enum logic [2:0] {
        RRI_OP_NONE                 = 3'b000,
        RRI_OP_RETURN               = 3'b001,
        RRI_OP_LITERAL_RETURN_OP    = 3'b010,
        RRI_OP_INTERRUPT_RETURN_OP  = 3'b011,
        RRI_OP_ROTATE_LEFT_CARRY_OP = 3'b100
    } rri_op_e;

    // Execution sequencer
    typedef enum logic [0:0] {
        RRI_ST_IDLE   = 1'b0,
        RRI_ST_RETURN = 1'b1
    } rri_state_e;
endpackage

// *** rri_stack.sv ***
`include "rri_consts.svh"

// Circular call stack; pointer wraps like the real part, no trap on overflow
module rri_stack (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   push_i,
    input  wire logic                   pop_i,
    input  wire logic [`RRI_PC_W-1:0]   push_data_i,
    output logic      [`RRI_PC_W-1:0]   stack_top_value_o
);
    import rri_pkg::*;

    logic [`RRI_PC_W-1:0] mem_q [`RRI_STACK_DEPTH];
    logic [`RRI_SP_W-1:0] sp_q;
    logic [`RRI_SP_W-1:0] sp_d;

    // Top entry sits one below the pointer
    assign stack_top_value_o = mem_q[sp_q - `RRI_SP_W'(1)];

    // Pointer next value; push wins if both asked in one cycle
    always_comb begin
        sp_d = sp_q;
        if (push_i) begin
            sp_d = sp_q + `RRI_SP_W'(1);
        end else if (pop_i) begin
            sp_d = sp_q - `RRI_SP_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_q <= `RRI_SP_RST;
        end else if (clk_en_i) begin
            sp_q <= sp_d;
        end
    end

    // Storage has no reset; contents are undefined until pushed
    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && push_i) begin
            mem_q[sp_q] <= push_data_i;
        end
    end
endmodule

// *** rri_core.sv ***
`include "rri_consts.svh"

// Overview of operation
// RQ1: Interrupt return pops stack into program counter
// RQ2: Interrupt return sets global interrupt enable bit
// RQ3: Interrupt return: one word, two cycles
// RQ4: Literal return writes 8-bit literal to accumulator
// RQ5: Literal return loads popped address, two cycles
// RQ6: Plain return pops stack, two cycles
// RQ7: Rotate left through carry, MSB into carry
// RQ8: Destination 0 to accumulator, 1 to register
// RQ9: Rotate one cycle; returns touch no flags
module rri_core (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       clk_en_i,
    input  wire logic                       instr_valid_i,
    input  wire rri_pkg::rri_op_e           instr_op_i,
    input  wire logic [`RRI_DATA_W-1:0]     literal_i,
    input  wire logic [`RRI_FADDR_W-1:0]    file_addr_i,
    input  wire logic                       dest_sel_i,
    input  wire logic [`RRI_DATA_W-1:0]     file_rdata_i,
    input  wire logic                       call_push_i,
    input  wire logic [`RRI_PC_W-1:0]       call_addr_i,
    input  wire logic                       irq_entry_i,
    output logic                            instr_ready_o,
    output logic                            instr_done_o,
    output logic [`RRI_PC_W-1:0]            program_counter_o,
    output logic [`RRI_DATA_W-1:0]          accum_o,
    output logic                            carry_o,
    output logic [`RRI_DATA_W-1:0]          interrupt_control_reg_o,
    output logic                            file_we_o,
    output logic [`RRI_FADDR_W-1:0]         file_addr_o,
    output logic [`RRI_DATA_W-1:0]          file_wdata_o
);
    import rri_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////////

    rri_state_e                 state_q;
    rri_state_e                 state_d;
    rri_op_e                    pend_op_q;
    rri_op_e                    pend_op_d;
    logic [`RRI_DATA_W-1:0]     pend_lit_q;
    logic [`RRI_DATA_W-1:0]     pend_lit_d;
    logic [`RRI_PC_W-1:0]       ret_addr_q;
    logic [`RRI_PC_W-1:0]       ret_addr_d;
    logic [`RRI_PC_W-1:0]       pc_q;
    logic [`RRI_PC_W-1:0]       pc_d;
    logic [`RRI_DATA_W-1:0]     acc_q;
    logic [`RRI_DATA_W-1:0]     acc_d;
    logic                       carry_q;
    logic                       carry_d;
    logic [`RRI_DATA_W-1:0]     interrupt_control_reg_q;
    logic [`RRI_DATA_W-1:0]     interrupt_control_reg_d;
    logic                       ready_q;
    logic                       ready_d;
    logic                       done_q;
    logic                       done_d;
    logic                       fwe_q;
    logic                       fwe_d;
    logic [`RRI_FADDR_W-1:0]    faddr_q;
    logic [`RRI_FADDR_W-1:0]    faddr_d;
    logic [`RRI_DATA_W-1:0]     fwdata_q;
    logic [`RRI_DATA_W-1:0]     fwdata_d;

    logic                       accept;
    logic                       is_return;
    logic                       stack_pop;
    logic [`RRI_PC_W-1:0]       stack_top_value;

    // Rotate through carry: returns {new carry, result}
    function automatic logic [`RRI_DATA_W:0] rot_left(input logic [`RRI_DATA_W-1:0] val,
                                                       input logic                   cin);
        rot_left = {val[`RRI_MSB_BIT], val[`RRI_DATA_W-2:0], cin};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    ////////////////////////////////////////////////////////////////////////////

    // Requests are only taken while idle; no queueing behind a return
    assign accept    = instr_valid_i && (state_q == RRI_ST_IDLE);
    assign is_return = (instr_op_i == RRI_OP_RETURN)
                    || (instr_op_i == RRI_OP_LITERAL_RETURN_OP)
                    || (instr_op_i == RRI_OP_INTERRUPT_RETURN_OP);
    // Pop in the first cycle so the top is latched before any new push
    assign stack_pop = accept && is_return; // RQ1 RQ5 RQ6

    rri_stack u_stack (
        .clk_sys_i         (clk_sys_i),
        .rst_b_i           (rst_b_i),
        .clk_en_i          (clk_en_i),
        .push_i            (call_push_i),
        .pop_i             (stack_pop),
        .push_data_i       (call_addr_i),
        .stack_top_value_o (stack_top_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    ////////////////////////////////////////////////////////////////////////////

    // All next values in one place; flags only move where named below
    always_comb begin
        logic [`RRI_DATA_W:0] rot;
        rot        = rot_left(file_rdata_i, carry_q);
        state_d    = state_q;
        pend_op_d  = pend_op_q;
        pend_lit_d = pend_lit_q;
        ret_addr_d = ret_addr_q;
        pc_d       = pc_q;
        acc_d      = acc_q;
        carry_d    = carry_q;
        interrupt_control_reg_d   = interrupt_control_reg_q;
        done_d     = 1'b0;
        fwe_d      = 1'b0;
        faddr_d    = faddr_q;
        fwdata_d   = fwdata_q;

        // Interrupt entry clears the enable; an interrupt return's commit below overrides it
        if (irq_entry_i) begin
            interrupt_control_reg_d[`RRI_GIE_BIT] = 1'b0;
        end

        unique case (state_q)
            RRI_ST_IDLE: begin
                if (accept && is_return) begin
                    // First of two cycles: capture target and literal
                    pend_op_d  = instr_op_i;
                    pend_lit_d = literal_i;
                    ret_addr_d = stack_top_value; // RQ1 RQ5 RQ6
                    state_d    = RRI_ST_RETURN; // RQ3
                end else if (accept && instr_op_i == RRI_OP_ROTATE_LEFT_CARRY_OP) begin
                    carry_d = rot[`RRI_DATA_W]; // RQ7 RQ9
                    faddr_d = file_addr_i;
                    if (dest_sel_i) begin
                        fwe_d    = 1'b1; // RQ8
                        fwdata_d = rot[`RRI_DATA_W-1:0]; // RQ7
                    end else begin
                        acc_d = rot[`RRI_DATA_W-1:0]; // RQ8
                    end
                    pc_d   = pc_q + `RRI_PC_W'(`RRI_WORDS_PER_OP);
                    done_d = 1'b1; // RQ9
                end else if (accept) begin
                    // Other opcodes belong elsewhere; just step past them
                    pc_d = pc_q + `RRI_PC_W'(`RRI_WORDS_PER_OP);
                end
            end
            RRI_ST_RETURN: begin
                // Second cycle: commit; no status flag is touched
                pc_d    = ret_addr_q; // RQ1 RQ5 RQ6
                done_d  = 1'b1; // RQ3 RQ5 RQ6 RQ9
                state_d = RRI_ST_IDLE;
                if (pend_op_q == RRI_OP_LITERAL_RETURN_OP) begin
                    acc_d = pend_lit_q; // RQ4
                end
                if (pend_op_q == RRI_OP_INTERRUPT_RETURN_OP) begin
                    interrupt_control_reg_d[`RRI_GIE_BIT] = 1'b1; // RQ2
                end
            end
        endcase

        // Ready follows the next state so a return's busy cycle shows at once
        // Costs one compare, but no stale ready edge after a commit
        ready_d = (state_d == RRI_ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////////////

    // Clock enable low freezes everything, pulses included
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q    <= RRI_ST_IDLE;
            pend_op_q  <= RRI_OP_NONE;
            pend_lit_q <= `RRI_ACC_RST;
            ret_addr_q <= `RRI_PC_RST;
            pc_q       <= `RRI_PC_RST;
            acc_q      <= `RRI_ACC_RST;
            carry_q    <= `RRI_CARRY_RST;
            interrupt_control_reg_q   <= `RRI_INTERRUPT_CONTROL_REG_RST;
            ready_q    <= 1'b1;
            done_q     <= 1'b0;
            fwe_q      <= 1'b0;
            faddr_q    <= `RRI_FADDR_RST;
            fwdata_q   <= `RRI_ACC_RST;
        end else if (clk_en_i) begin
            state_q    <= state_d;
            pend_op_q  <= pend_op_d;
            pend_lit_q <= pend_lit_d;
            ret_addr_q <= ret_addr_d;
            pc_q       <= pc_d;
            acc_q      <= acc_d;
            carry_q    <= carry_d;
            interrupt_control_reg_q   <= interrupt_control_reg_d;
            ready_q    <= ready_d;
            done_q     <= done_d;
            fwe_q      <= fwe_d;
            faddr_q    <= faddr_d;
            fwdata_q   <= fwdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // Every output is a flop
    assign instr_ready_o           = ready_q;
    assign instr_done_o            = done_q;
    assign program_counter_o       = pc_q;
    assign accum_o                 = acc_q;
    assign carry_o                 = carry_q;
    assign interrupt_control_reg_o = interrupt_control_reg_q;
    assign file_we_o               = fwe_q;
    assign file_addr_o             = faddr_q;
    assign file_wdata_o            = fwdata_q;
endmodule

// *** rri_core_assertions.sv ***
`include "rri_consts.svh"

// Sees only core ports; clock enable assumed high around each instruction
module rri_core_assertions
    import rri_pkg::*;
(
    input wire logic                    clk_sys_i,
    input wire logic                    rst_b_i,
    input wire logic                    clk_en_i,
    input wire logic                    instr_valid_i,
    input wire rri_op_e                 instr_op_i,
    input wire logic [`RRI_DATA_W-1:0]  literal_i,
    input wire logic [`RRI_FADDR_W-1:0] file_addr_i,
    input wire logic                    dest_sel_i,
    input wire logic [`RRI_DATA_W-1:0]  file_rdata_i,
    input wire logic                    instr_ready_o,
    input wire logic                    instr_done_o,
    input wire logic [`RRI_PC_W-1:0]    program_counter_o,
    input wire logic [`RRI_DATA_W-1:0]  accum_o,
    input wire logic                    carry_o,
    input wire logic [`RRI_DATA_W-1:0]  interrupt_control_reg_o,
    input wire logic                    file_we_o,
    input wire logic [`RRI_FADDR_W-1:0] file_addr_o,
    input wire logic [`RRI_DATA_W-1:0]  file_wdata_o
);
    logic rot_take;
    logic ret_take;

    // Which instruction is taken at this edge
    assign rot_take = clk_en_i && instr_valid_i && instr_ready_o && instr_op_i == RRI_OP_ROTATE_LEFT_CARRY_OP;
    assign ret_take = clk_en_i && instr_valid_i && instr_ready_o && instr_op_i inside {RRI_OP_RETURN,
                      RRI_OP_LITERAL_RETURN_OP, RRI_OP_INTERRUPT_RETURN_OP};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // Busy gap then commit
    sequence s_ret_finish;
        !instr_ready_o && !instr_done_o ##1 instr_done_o && instr_ready_o;
    endsequence

    a_rot_one_cycle: assert property (rot_take |=> instr_done_o && instr_ready_o)
        else $error("rotate did not finish in one cycle");
    a_rot_shift_carry: assert property (rot_take |=> carry_o == $past(file_rdata_i[`RRI_MSB_BIT]) &&
        (($past(dest_sel_i) ? file_wdata_o : accum_o) == {$past(file_rdata_i[6:0]), $past(carry_o)}))
        else $error("rotate result or carry wrong");
    a_rot_to_file: assert property (rot_take && dest_sel_i |=> file_we_o && file_addr_o == $past(file_addr_i)
        && $stable(accum_o)) else $error("rotate to register wrong");
    a_rot_to_acc: assert property (rot_take && !dest_sel_i |=> !file_we_o)
        else $error("rotate to accumulator wrote register");
    a_rot_pc_step: assert property (rot_take |=> program_counter_o == $past(program_counter_o) + 1'b1)
        else $error("rotate did not step counter");
    a_ret_two_cycle: assert property (ret_take |=> s_ret_finish)
        else $error("return not two cycles");
    a_lit_to_acc: assert property (ret_take && instr_op_i == RRI_OP_LITERAL_RETURN_OP |->
        ##2 accum_o == $past(literal_i, 2)) else $error("literal not in accumulator");
    a_iret_gie_set: assert property (ret_take && instr_op_i == RRI_OP_INTERRUPT_RETURN_OP |->
        ##2 interrupt_control_reg_o[`RRI_GIE_BIT]) else $error("interrupt enable not set");
    a_ret_keep_carry: assert property (ret_take |=> $stable(carry_o)[*2])
        else $error("return changed carry");
endmodule

bind rri_core rri_core_assertions u_rri_core_assertions (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .literal_i(literal_i),
    .file_addr_i(file_addr_i), .dest_sel_i(dest_sel_i), .file_rdata_i(file_rdata_i),
    .instr_ready_o(instr_ready_o), .instr_done_o(instr_done_o), .program_counter_o(program_counter_o),
    .accum_o(accum_o), .carry_o(carry_o), .interrupt_control_reg_o(interrupt_control_reg_o),
    .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o));

// *** rri_tb.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rri_pkg::*;
    logic        clk_sys_i, rst_b_i, clk_en, valid, dest, push, irq;
    rri_op_e     op;
    logic [7:0]  literal, rdata, acc, interrupt_control_reg, wdata;
    logic [6:0]  faddr, faddr_o;
    logic [14:0] call_addr, pc;
    logic        ready, done, carry, we;
    int          m_pc, m_acc, m_c, m_gie, err_count, compares;
    int          stk[$];

    rri_core u_rri_core (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en), .instr_valid_i(valid),
        .instr_op_i(op), .literal_i(literal), .file_addr_i(faddr), .dest_sel_i(dest), .file_rdata_i(rdata),
        .call_push_i(push), .call_addr_i(call_addr), .irq_entry_i(irq), .instr_ready_o(ready),
        .instr_done_o(done), .program_counter_o(pc), .accum_o(acc), .carry_o(carry),
        .interrupt_control_reg_o(interrupt_control_reg), .file_we_o(we), .file_addr_o(faddr_o), .file_wdata_o(wdata));

    always #20 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////
    // Compare and sequencing helpers
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step;
        @(posedge clk_sys_i);
        #1;
    endtask

    // Push or interrupt entry; gap edge avoids double drive
    task automatic pulse(input bit is_irq, input int addr);
        call_addr = 15'(addr);
        if (is_irq) irq = 1; else push = 1;
        step;
        push = 0;
        irq = 0;
        step;
        if (is_irq) m_gie = 0;
        else begin
            stk.push_back(addr & 'h7fff);
        end
    endtask

    // Valid stays high through a return's busy cycle to prove refusal
    task automatic run(input rri_op_e o, input int k, input int rd, input bit d);
        int res, fa;
        k &= 'hff;
        rd &= 'hff;
        fa = $urandom % 128;
        valid = 1; op = o; literal = 8'(k); rdata = 8'(rd); dest = d; faddr = 7'(fa);
        step;
        if (o == RRI_OP_ROTATE_LEFT_CARRY_OP) begin
            res = ((rd << 1) | m_c) & 'hff;
            m_c = rd >> 7;
            m_pc = (m_pc + 1) % 32768;
            if (!d) m_acc = res;
            chk_val(we, d);
            if (d) chk_val({faddr_o, wdata}, {7'(fa), 8'(res)});
        end else begin
            chk_val({ready, done}, 0);
            step;
            m_pc = stk.pop_back();
            if (o == RRI_OP_LITERAL_RETURN_OP) m_acc = k;
            if (o == RRI_OP_INTERRUPT_RETURN_OP) m_gie = 1;
        end
        chk_val(done, 1);
        chk_val(pc, m_pc);
        chk_val(acc, m_acc);
        chk_val(carry, m_c);
        chk_val(interrupt_control_reg, m_gie << 7);
    endtask

    task automatic test_done;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk_sys_i = 0; rst_b_i = 0; clk_en = 1; valid = 0; op = RRI_OP_NONE; literal = 0; faddr = 0;
        dest = 0; rdata = 0; push = 0; irq = 0; call_addr = 0;
        err_count = 0; compares = 0; m_pc = 0; m_acc = 0; m_c = 0; m_gie = 0;
        void'($urandom(77474));
        repeat (20) @(posedge clk_sys_i);
        #1 rst_b_i = 1;
        chk_val({ready, done, we, carry, interrupt_control_reg, pc}, {4'b1000, 8'h00, 15'h0000});
        run(RRI_OP_ROTATE_LEFT_CARRY_OP, 0, 'he6, 0);
        run(RRI_OP_ROTATE_LEFT_CARRY_OP, 0, 'he6, 1);
        repeat (30) run(RRI_OP_ROTATE_LEFT_CARRY_OP, 0, $urandom, 1'($urandom));
        // Clock enable low: a waiting rotate must not move any state
        clk_en = 0;
        rdata = 8'($urandom);
        repeat (3) step;
        chk_val({done, ready, pc, acc, carry}, {2'b11, 15'(m_pc), 8'(m_acc), 1'(m_c)});
        // Idle opcode only steps the counter, with no done and no flag
        clk_en = 1;
        op = RRI_OP_NONE;
        step;
        m_pc = (m_pc + 1) % 32768;
        chk_val({done, carry, pc}, {1'b0, 1'(m_c), 15'(m_pc)});
        // Three pushes, then unwind in LIFO order with a rotate wedged in
        for (int i = 0; i < 6; i++) begin
            valid = 0;
            repeat (3) pulse(0, $urandom);
            pulse(1, 0);
            run(RRI_OP_RETURN, 0, 0, 0);
            run(RRI_OP_LITERAL_RETURN_OP, i == 0 ? 0 : i == 1 ? 'hff : $urandom, 0, 0);
            run(RRI_OP_ROTATE_LEFT_CARRY_OP, 0, $urandom, i[0]);
            run(RRI_OP_INTERRUPT_RETURN_OP, 0, 0, 0);
        end
        valid = 0;
        step;
        test_done;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #160000;
        err_count++;
        test_done;
    end
endmodule
